// File: hw/stc_timer_ctl.sv
/*
  Control, compare, capture and pin routing slice of a 16-bit timer, with
  an APB register slave. Assumes pins are synchronous-sampled by the edge
  detector, timer0 compare outputs come from elsewhere on this clock.
*/
`timescale 1ns/1ns
module stc_timer_ctl
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stc_pkg::ADDR_W-1:0] paddr,
  input wire logic [stc_pkg::DATA_W-1:0] pwdata,
  output logic [stc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins and sources
  input wire logic capture_input_pin,
  input wire logic analog_cmp_out,
  input wire logic external_count_pin,
  input wire logic timer0_compare_out_a,
  input wire logic timer0_compare_out_b,
  // Interrupt handshake
  input wire logic global_irq_enable,
  input wire logic capture_irq_ack,
  input wire logic compare_a_irq_ack,
  input wire logic compare_b_irq_ack,
  output logic capture_irq,
  output logic compare_a_irq,
  output logic compare_b_irq,
  // Compare outputs
  output logic compare_out_a,
  output logic compare_out_b,
  output logic [7:0] routed_compare_pin,
  output logic [7:0] routed_compare_pin_oe
);
  import stc_pkg::*;

  typedef struct packed {
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic cap_src;
    logic [15:0] cnt;
    logic [15:0] ocra;
    logic [15:0] ocrb;
    logic [15:0] icr;
    logic [7:0] temp;
    logic [7:0] mask;
    logic flag_cap;
    logic flag_a;
    logic flag_b;
    logic [7:0] pin_oe;
    logic [7:0] route_lo;
    logic [7:0] route_hi;
    logic [PRE_W-1:0] presc;
    logic block;
    logic oca;
    logic ocb;
    logic [7:0] pin_out;
    logic irq_cap;
    logic irq_a;
    logic irq_b;
    logic rdy;
    logic [DATA_W-1:0] rdata;
    logic err;
  } stc_state_s;

  stc_state_s r_reg;
  stc_state_s r_next;

  stc_edge_if edge_if ();

  // ==========================================================
  // Helpers
  function automatic logic [15:0] top_of(input logic [3:0] wgm,
    input logic [15:0] ocra, input logic [15:0] icr);
    logic [15:0] t;
    t = TOP_MAX;
    unique case (wgm)
      4'h1, 4'h5: t = TOP_8;
      4'h2, 4'h6: t = TOP_9;
      4'h3, 4'h7: t = TOP_10;
      4'h4, 4'h9, 4'hb, 4'hf: t = ocra;
      4'h8, 4'ha, 4'hc, 4'he: t = icr;
      default: t = TOP_MAX;
    endcase
    return t;
  endfunction : top_of

  // Output unit: non-PWM follows the mode on a match, PWM modes clear or
  // set on match and do the opposite at bottom (up-count only)
  function automatic logic oc_next(input logic [1:0] com,
    input logic non_pwm, input logic cur, input logic hit,
    input logic bottom);
    logic v;
    v = cur;
    if (non_pwm)
    begin
      if (hit)
      begin
        unique case (com)
          COM_TOGGLE: v = ~cur;
          COM_CLEAR: v = 1'b0;
          COM_SET: v = 1'b1;
          default: v = cur;
        endcase
      end
    end
    else if (com[1])
    begin
      if (hit)
        v = ~com[0];
      else if (bottom)
        v = com[0];
    end
    return v;
  endfunction : oc_next

  function automatic logic route_src(input logic [1:0] sel,
    input logic t0a, input logic t0b, input logic t1a, input logic t1b);
    logic v;
    unique case (sel)
      2'b00: v = t0a;
      2'b01: v = t0b;
      2'b10: v = t1a;
      2'b11: v = t1b;
    endcase
    return v;
  endfunction : route_src

  // ==========================================================
  // Pin edge detection
  assign edge_if.cap_raw = r_reg.cap_src ? analog_cmp_out
                                         : capture_input_pin;
  // The count pin is sampled even while the port drives it out
  assign edge_if.cnt_raw = external_count_pin;

  stc_pin_edge u_edge
  (
    .pclk(pclk),
    .presetn(presetn),
    .e(edge_if.detect)
  );

  // ==========================================================
  // Next state
  logic [3:0] wgm;
  logic non_pwm;
  logic icr_top;
  logic [15:0] top;
  logic tick;
  logic hit_a;
  logic hit_b;
  logic cap_evt;
  logic bottom;
  logic access;
  logic done;
  logic [7:0] idx;
  logic [7:0] wb;
  logic [15:0] route;
  logic force_a;
  logic force_b;
  logic cnt_wr;
  logic clr_cap;
  logic clr_a;
  logic clr_b;

  always_comb
  begin
    r_next = r_reg;
    wgm = {r_reg.ctl_b[4:3], r_reg.ctl_a[1:0]};
    non_pwm = (wgm == WGM_NORMAL) || (wgm == WGM_CTC_OCRA)
              || (wgm == WGM_CTC_ICR);
    icr_top = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == WGM_CTC_ICR)
              || (wgm == 4'he);
    top = top_of(wgm, r_reg.ocra, r_reg.icr);
    access = psel & penable;
    done = access & r_reg.rdy;
    idx = paddr[9:2];
    wb = pwdata[7:0];
    route = {r_reg.route_hi, r_reg.route_lo};
    force_a = 1'b0;
    force_b = 1'b0;
    cnt_wr = 1'b0;
    clr_cap = capture_irq_ack;
    clr_a = compare_a_irq_ack;
    clr_b = compare_b_irq_ack;

    // Free-running prescaler shared by all taps
    r_next.presc = r_reg.presc + 1'b1;
    unique case (stc_clk_sel_e'(r_reg.ctl_b[2:0]))
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (r_reg.presc & PRE_M8) == PRE_M8;
      CS_DIV64: tick = (r_reg.presc & PRE_M64) == PRE_M64;
      CS_DIV256: tick = (r_reg.presc & PRE_M256) == PRE_M256;
      CS_DIV1024: tick = r_reg.presc == PRE_M1024;
      CS_EXT_FALL: tick = edge_if.cnt_fall;
      CS_EXT_RISE: tick = edge_if.cnt_rise;
    endcase

    // Matches seen on a tick mark equality before the count moves, so the
    // flag lands on the same clock edge that moves the count
    hit_a = tick & ~r_reg.block & (r_reg.cnt == r_reg.ocra);
    hit_b = tick & ~r_reg.block & (r_reg.cnt == r_reg.ocrb);
    bottom = tick & (r_reg.cnt == top);
    if (tick)
    begin
      r_next.cnt = (r_reg.cnt == top) ? RST_WORD : r_reg.cnt + 16'h0001;
      r_next.block = 1'b0;
    end

    // Capture event on the chosen edge, gated off when capture is TOP
    cap_evt = r_reg.ctl_b[CES_BIT] ? edge_if.cap_rise
                                   : edge_if.cap_fall;
    cap_evt = cap_evt & ~icr_top;
    if (cap_evt)
      r_next.icr = r_reg.cnt;

    // ----------------------------------------------------------
    // APB: answer one cycle into the access phase
    r_next.rdy = access & ~r_reg.rdy;
    if (access & ~r_reg.rdy)
    begin
      r_next.err = paddr[1:0] != 2'b00;
      r_next.rdata = '0;
      unique case (idx)
        IDX_FLAGS: r_next.rdata[7:0] = {2'b00, r_reg.flag_cap, 2'b00,
                                        r_reg.flag_b, r_reg.flag_a, 1'b0};
        IDX_MASK: r_next.rdata[7:0] = r_reg.mask;
        IDX_CTL_A: r_next.rdata[7:0] = r_reg.ctl_a;
        IDX_CTL_B: r_next.rdata[7:0] = r_reg.ctl_b;
        IDX_CTL_C: r_next.rdata[7:0] = RST_BYTE;
        IDX_CAP_SRC: r_next.rdata[0] = r_reg.cap_src;
        IDX_CNT_L: r_next.rdata[7:0] = r_reg.cnt[7:0];
        IDX_ICR_L: r_next.rdata[7:0] = r_reg.icr[7:0];
        IDX_OCRA_L: r_next.rdata[7:0] = r_reg.ocra[7:0];
        IDX_OCRB_L: r_next.rdata[7:0] = r_reg.ocrb[7:0];
        IDX_CNT_H, IDX_ICR_H, IDX_OCRA_H, IDX_OCRB_H:
          r_next.rdata[7:0] = r_reg.temp;
        IDX_PIN_OE: r_next.rdata[7:0] = r_reg.pin_oe;
        IDX_ROUTE_LO: r_next.rdata[7:0] = r_reg.route_lo;
        IDX_ROUTE_HI: r_next.rdata[7:0] = r_reg.route_hi;
        default: r_next.err = 1'b1;
      endcase
      // A refused access must not leak register contents
      if (r_next.err)
        r_next.rdata = '0;
    end

    // Side effects only on the completing edge, never on an error
    if (done & ~r_reg.err & ~pwrite)
    begin
      unique case (idx)
        IDX_CNT_L: r_next.temp = r_reg.cnt[15:8];
        IDX_ICR_L: r_next.temp = r_reg.icr[15:8];
        IDX_OCRA_L: r_next.temp = r_reg.ocra[15:8];
        IDX_OCRB_L: r_next.temp = r_reg.ocrb[15:8];
        default: r_next.temp = r_reg.temp;
      endcase
    end
    if (done & ~r_reg.err & pwrite)
    begin
      unique case (idx)
        IDX_FLAGS:
        begin
          clr_cap = clr_cap | wb[IE_CAP_BIT];
          clr_a = clr_a | wb[IE_A_BIT];
          clr_b = clr_b | wb[IE_B_BIT];
        end
        IDX_MASK: r_next.mask = wb & MASK_USED;
        IDX_CTL_A: r_next.ctl_a = wb;
        IDX_CTL_B: r_next.ctl_b = wb & CTL_B_USED;
        IDX_CTL_C:
        begin
          // Strobes only: nothing of this register is stored
          force_a = wb[FOC_A_BIT] & non_pwm;
          force_b = wb[FOC_B_BIT] & non_pwm;
        end
        IDX_CAP_SRC: r_next.cap_src = wb[0];
        IDX_CNT_H, IDX_ICR_H, IDX_OCRA_H, IDX_OCRB_H:
          r_next.temp = wb;
        IDX_CNT_L:
        begin
          r_next.cnt = {r_reg.temp, wb};
          r_next.block = 1'b1;
          cnt_wr = 1'b1;
        end
        IDX_ICR_L: r_next.icr = {r_reg.temp, wb};
        IDX_OCRA_L: r_next.ocra = {r_reg.temp, wb};
        IDX_OCRB_L: r_next.ocrb = {r_reg.temp, wb};
        IDX_PIN_OE: r_next.pin_oe = wb;
        IDX_ROUTE_LO: r_next.route_lo = wb;
        IDX_ROUTE_HI: r_next.route_hi = wb;
        default: r_next.temp = r_reg.temp;
      endcase
    end

    // ----------------------------------------------------------
    // Compare outputs; forced matches leave flags and counter alone
    r_next.oca = oc_next(r_reg.ctl_a[7:6], non_pwm, r_reg.oca,
                         hit_a | force_a, bottom & ~cnt_wr);
    r_next.ocb = oc_next(r_reg.ctl_a[5:4], non_pwm, r_reg.ocb,
                         hit_b | force_b, bottom & ~cnt_wr);

    // Flags: a set in the same cycle as a clear wins
    r_next.flag_cap = (r_reg.flag_cap & ~clr_cap) | cap_evt
                      | (icr_top & bottom);
    r_next.flag_a = (r_reg.flag_a & ~clr_a) | hit_a;
    r_next.flag_b = (r_reg.flag_b & ~clr_b) | hit_b;

    r_next.irq_cap = r_reg.mask[IE_CAP_BIT] & global_irq_enable
                     & r_reg.flag_cap;
    r_next.irq_a = r_reg.mask[IE_A_BIT] & global_irq_enable
                   & r_reg.flag_a;
    r_next.irq_b = r_reg.mask[IE_B_BIT] & global_irq_enable
                   & r_reg.flag_b;

    // Routing follows the unit outputs, independent of compare mode
    for (int i = 0; i < 8; i++)
    begin
      r_next.pin_out[i] = route_src(route[2*i +: 2], timer0_compare_out_a,
        timer0_compare_out_b, r_reg.oca, r_reg.ocb);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // ==========================================================
  // Outputs straight from the state register
  assign prdata = r_reg.rdata;
  assign pready = r_reg.rdy;
  assign pslverr = r_reg.err & r_reg.rdy;
  assign capture_irq = r_reg.irq_cap;
  assign compare_a_irq = r_reg.irq_a;
  assign compare_b_irq = r_reg.irq_b;
  assign compare_out_a = r_reg.oca;
  assign compare_out_b = r_reg.ocb;
  assign routed_compare_pin = r_reg.pin_out;
  assign routed_compare_pin_oe = r_reg.pin_oe;

endmodule : stc_timer_ctl

// File: hw/stc_pkg.sv
/*
  Constants, register indices, field positions and modes for the 16-bit
  timer control slice. Assumes an APB master with 32-bit data; registers are
  byte wide and sit in the low bits of one aligned word each.
*/
package stc_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h36;
  localparam logic [7:0] IDX_MASK = 8'h6f;
  localparam logic [7:0] IDX_CTL_A = 8'h80;
  localparam logic [7:0] IDX_CTL_B = 8'h81;
  localparam logic [7:0] IDX_CTL_C = 8'h82;
  localparam logic [7:0] IDX_CAP_SRC = 8'h83;
  localparam logic [7:0] IDX_CNT_L = 8'h84;
  localparam logic [7:0] IDX_CNT_H = 8'h85;
  localparam logic [7:0] IDX_ICR_L = 8'h86;
  localparam logic [7:0] IDX_ICR_H = 8'h87;
  localparam logic [7:0] IDX_OCRA_L = 8'h88;
  localparam logic [7:0] IDX_OCRA_H = 8'h89;
  localparam logic [7:0] IDX_OCRB_L = 8'h8a;
  localparam logic [7:0] IDX_OCRB_H = 8'h8b;
  localparam logic [7:0] IDX_PIN_OE = 8'he2;
  localparam logic [7:0] IDX_ROUTE_LO = 8'he8;
  localparam logic [7:0] IDX_ROUTE_HI = 8'he9;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int CES_BIT = 6;
  localparam int FOC_A_BIT = 7;
  localparam int FOC_B_BIT = 6;
  localparam int IE_CAP_BIT = 5;
  localparam int IE_B_BIT = 2;
  localparam int IE_A_BIT = 1;
  localparam logic [7:0] MASK_USED = 8'h26;
  localparam logic [7:0] CTL_B_USED = 8'hdf;

  // ==========================================================
  // Clock select codes
  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } stc_clk_sel_e;

  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_M8 = 10'h007;
  localparam logic [9:0] PRE_M64 = 10'h03f;
  localparam logic [9:0] PRE_M256 = 10'h0ff;
  localparam logic [9:0] PRE_M1024 = 10'h3ff;

  // ==========================================================
  // Waveform modes, tops and compare output actions
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_OCRA = 4'h4;
  localparam logic [3:0] WGM_CTC_ICR = 4'hc;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [1:0] COM_TOGGLE = 2'b01;
  localparam logic [1:0] COM_CLEAR = 2'b10;
  localparam logic [1:0] COM_SET = 2'b11;

endpackage : stc_pkg

// File: hw/stc_edge_if.sv
/*
  Pin samples and edge pulses between the core and the pin edge detector.
  Assumes both ends run on the same bus clock.
*/
`timescale 1ns/1ns
interface stc_edge_if;
  logic cap_raw;
  logic cnt_raw;
  logic cap_rise;
  logic cap_fall;
  logic cnt_rise;
  logic cnt_fall;

  modport detect (input cap_raw, input cnt_raw, output cap_rise,
    output cap_fall, output cnt_rise, output cnt_fall);
  modport core (output cap_raw, output cnt_raw, input cap_rise,
    input cap_fall, input cnt_rise, input cnt_fall);
endinterface : stc_edge_if

// File: hw/stc_pin_edge.sv
/*
  Two-stage synchronisers and edge detectors for the capture source and
  the external count pin. Assumes raw inputs may change at any time.
*/
`timescale 1ns/1ns
module stc_pin_edge
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin samples and pulses
  stc_edge_if.detect e
);

  typedef struct packed {
    logic cap_s1;
    logic cap_s2;
    logic cap_s3;
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_s3;
  } stc_edge_s;

  stc_edge_s r_reg;
  stc_edge_s r_next;

  // ==========================================================
  // Sampling chain; edges look only at the settled stages
  always_comb
  begin
    r_next = r_reg;
    r_next.cap_s1 = e.cap_raw;
    r_next.cap_s2 = r_reg.cap_s1;
    r_next.cap_s3 = r_reg.cap_s2;
    r_next.cnt_s1 = e.cnt_raw;
    r_next.cnt_s2 = r_reg.cnt_s1;
    r_next.cnt_s3 = r_reg.cnt_s2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign e.cap_rise = r_reg.cap_s2 & ~r_reg.cap_s3;
  assign e.cap_fall = ~r_reg.cap_s2 & r_reg.cap_s3;
  assign e.cnt_rise = r_reg.cnt_s2 & ~r_reg.cnt_s3;
  assign e.cnt_fall = ~r_reg.cnt_s2 & r_reg.cnt_s3;

endmodule : stc_pin_edge

// File: verification/stc_pin_model.sv
/*
  Model of the pins around the timer slice: capture pin, comparator
  output, external count pin and the timer0 compare outputs.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/1ns
module stc_pin_model
(
  // Clock
  input wire logic pclk,
  // Pin levels toward the timer
  output logic capture_input_pin,
  output logic analog_cmp_out,
  output logic external_count_pin,
  output logic timer0_compare_out_a,
  output logic timer0_compare_out_b
);
  // ==========================================================
  // Timer0 output a toggles every cycle and b every second cycle so a stale route shows
  logic [1:0] phase_reg = 2'h0;
  always @(posedge pclk)
    phase_reg <= phase_reg + 2'h1;
  assign timer0_compare_out_a = phase_reg[0];
  assign timer0_compare_out_b = phase_reg[1];
  initial
  begin
    capture_input_pin = 1'b0;
    analog_cmp_out = 1'b0;
    external_count_pin = 1'b0;
  end
  // ==========================================================
  // Half periods of three clocks keep edges well above sampling
  task count_pulses(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge pclk);
      external_count_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      external_count_pin <= 1'b0;
    end
  endtask : count_pulses
  task set_cap(input logic v);
    @(posedge pclk);
    capture_input_pin <= v;
  endtask : set_cap
  task set_cmp(input logic v);
    @(posedge pclk);
    analog_cmp_out <= v;
  endtask : set_cmp
endmodule : stc_pin_model

// File: verification/stc_timer_ctl_chk.sv
/*
  Port assertions for the timer slice. Assumes one clock domain and an
  APB master that holds each request until pready.
*/
`timescale 1ns/1ns
module stc_timer_ctl_chk
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stc_pkg::ADDR_W-1:0] paddr,
  input wire logic [stc_pkg::DATA_W-1:0] pwdata,
  input wire logic [stc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources, interrupts and pins
  input wire logic timer0_compare_out_a,
  input wire logic timer0_compare_out_b,
  input wire logic global_irq_enable,
  input wire logic capture_irq,
  input wire logic compare_a_irq,
  input wire logic compare_b_irq,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  input wire logic [7:0] routed_compare_pin,
  input wire logic [7:0] routed_compare_pin_oe
);
  import stc_pkg::*;
  logic acc;
  logic [3:0] src;
  assign acc = psel && penable && pready;
  assign src = {compare_out_b, compare_out_a, timer0_compare_out_b,
    timer0_compare_out_a};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus timing
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  property p_ready;
    s_setup |=> s_wait;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready not after one wait state");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err)
    else $error("error without pready or with data");
  property p_misalign;
    acc && paddr[1:0] != 2'h0 |-> pslverr;
  endproperty
  a_misalign: assert property (p_misalign)
    else $error("misaligned access not refused");
  property p_upper;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("read data above byte not zero");
  property p_force_rd;
    acc && !pwrite && paddr == {IDX_CTL_C, 2'h0} |-> prdata == 32'h0;
  endproperty
  a_force_rd: assert property (p_force_rd)
    else $error("force bits read nonzero");
  // ==========================================================
  // Pins and interrupts
  property p_oe;
    !(acc && pwrite && paddr == {IDX_PIN_OE, 2'h0})
      |=> $stable(routed_compare_pin_oe);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enables changed without a write");
  for (genvar n = 0; n < 8; n++)
  begin : g_route
    property p_route;
      routed_compare_pin[n] ? |$past(src) : ~&$past(src);
    endproperty
    a_route: assert property (p_route)
      else $error("routed pin matches no source");
  end
  property p_gate;
    !global_irq_enable |=> !(capture_irq || compare_a_irq || compare_b_irq);
  endproperty
  a_gate: assert property (p_gate)
    else $error("interrupt without global enable");
  sequence s_force;
    acc && pwrite && paddr == {IDX_CTL_C, 2'h0} && pwdata[7:6] != 2'h0;
  endsequence
  property p_force;
    s_force |=> (!$rose(compare_a_irq) && !$rose(compare_b_irq)) [*4];
  endproperty
  a_force: assert property (p_force)
    else $error("forced match raised an interrupt");
endmodule : stc_timer_ctl_chk
bind stc_timer_ctl stc_timer_ctl_chk chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .timer0_compare_out_a, .timer0_compare_out_b, .global_irq_enable,
  .capture_irq, .compare_a_irq, .compare_b_irq, .compare_out_a,
  .compare_out_b, .routed_compare_pin, .routed_compare_pin_oe);

// File: verification/stc_timer_ctl_tb.sv
/*
  Self-checking bench for the timer slice. Assumes the pin model in
  its own file and the checker bound to the design.
*/
`timescale 1ns/1ns
module stc_timer_ctl_tb;
  import stc_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic capture_input_pin, analog_cmp_out, external_count_pin;
  logic timer0_compare_out_a, timer0_compare_out_b, global_irq_enable;
  logic capture_irq_ack, compare_a_irq_ack, compare_b_irq_ack;
  logic capture_irq, compare_a_irq, compare_b_irq;
  logic compare_out_a, compare_out_b;
  logic [7:0] routed_compare_pin, routed_compare_pin_oe;
  logic [32:0] expq [$];
  logic [3:0] src_q;
  logic [15:0] route;
  logic [7:0] rv [3];
  logic [7:0] regs [3] = '{IDX_PIN_OE, IDX_ROUTE_LO, IDX_ROUTE_HI};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  stc_timer_ctl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .capture_input_pin,
    .analog_cmp_out, .external_count_pin, .timer0_compare_out_a,
    .timer0_compare_out_b, .global_irq_enable, .capture_irq_ack,
    .compare_a_irq_ack, .compare_b_irq_ack, .capture_irq, .compare_a_irq,
    .compare_b_irq, .compare_out_a, .compare_out_b, .routed_compare_pin,
    .routed_compare_pin_oe);
  stc_pin_model pins (.pclk, .capture_input_pin, .analog_cmp_out,
    .external_count_pin, .timer0_compare_out_a, .timer0_compare_out_b);
  // ==========================================================
  // Shared tasks
  task check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'h0}, d);
  endtask : wr
  task rd(input logic [7:0] idx, input logic [7:0] e);
    expq.push_back({25'h0, e});
    apb(1'b0, {idx, 2'h0}, 8'h00);
  endtask : rd
  task rde(input logic [ADDR_W-1:0] a);
    expq.push_back({1'b1, 32'h0});
    apb(1'b0, a, 8'h00);
  endtask : rde
  function automatic logic [7:0] route_exp(input logic [15:0] r,
    input logic [3:0] s);
    logic [7:0] e;
    for (int n = 0; n < 8; n++)
      e[n] = s[r[2*n +: 2]];
    return e;
  endfunction : route_exp
  // ==========================================================
  // Monitor: read answers against the oldest note; hang guard
  always @(posedge pclk)
  begin
    cyc++;
    src_q <= {compare_out_b, compare_out_a, timer0_compare_out_b,
      timer0_compare_out_a};
    if (cyc > 6000)
    begin
      n_fail++;
      give_verdict();
    end
    else if (pready === 1'b1 && pwrite === 1'b0)
      check({pslverr, prdata}, expq.pop_front());
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    int n;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, global_irq_enable, capture_irq_ack} = '0;
    {compare_a_irq_ack, compare_b_irq_ack} = '0;
    rv[0] = 8'($urandom(63));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
      rd(regs[i], RST_BYTE);
    for (int i = 0; i < 3; i++)
    begin
      rv[i] = 8'($urandom());
      wr(regs[i], rv[i]);
      rd(regs[i], rv[i]);
    end
    check(routed_compare_pin_oe, rv[0]);
    apb(1'b1, {IDX_PIN_OE, 2'h1}, ~rv[0]);
    rde({IDX_PIN_OE, 2'h1});
    rde(10'h0);
    rd(IDX_PIN_OE, rv[0]);
    // Forced matches with the counter stopped, interrupts open
    wr(IDX_MASK, MASK_USED);
    global_irq_enable <= 1'b1;
    wr(IDX_CTL_A, {COM_TOGGLE, COM_SET, 4'h0});
    wr(IDX_CTL_C, 8'hc0);
    repeat (3) @(posedge pclk);
    check(compare_out_a, 1'b1);
    check(compare_out_b, 1'b1);
    wr(IDX_CTL_C, 8'h80);
    rd(IDX_CTL_C, 8'h00);
    rd(IDX_FLAGS, 8'h00);
    check(compare_out_a, 1'b0);
    // Routing against last cycle's sources
    wr(IDX_PIN_OE, 8'hff);
    for (int k = 0; k < 2; k++)
    begin
      route = 16'($urandom());
      wr(IDX_ROUTE_LO, route[7:0]);
      wr(IDX_ROUTE_HI, route[15:8]);
      // Routed pins lag the new select by one clock
      @(posedge pclk);
      repeat (4)
      begin
        @(negedge pclk);
        check(routed_compare_pin, route_exp(route, src_q));
      end
    end
    // Shared high latch, reused for a second register
    wr(IDX_CNT_H, 8'h12);
    wr(IDX_CNT_L, 8'h34);
    wr(IDX_OCRB_H, 8'h80);
    wr(IDX_OCRB_L, 8'h00);
    wr(IDX_OCRA_H, 8'h00);
    wr(IDX_OCRA_L, 8'h10);
    rd(IDX_CNT_L, 8'h34);
    rd(IDX_CNT_H, 8'h12);
    rd(IDX_OCRB_L, 8'h00);
    rd(IDX_OCRB_H, 8'h80);
    // Running match, interrupt, acknowledge
    wr(IDX_CNT_H, 8'h00);
    wr(IDX_CNT_L, 8'h00);
    wr(IDX_CTL_B, {5'h0, CS_DIV1});
    n = 0;
    while (compare_a_irq !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge pclk);
    end
    check({compare_b_irq, compare_a_irq}, 2'b01);
    wr(IDX_CTL_B, 8'h00);
    compare_a_irq_ack <= 1'b1;
    @(posedge pclk);
    compare_a_irq_ack <= 1'b0;
    rd(IDX_FLAGS, 8'h00);
    // A counter write landing on the compare value is not matched
    wr(IDX_CTL_B, {5'h0, CS_DIV1});
    wr(IDX_CNT_H, 8'h00);
    wr(IDX_CNT_L, 8'h10);
    wr(IDX_CTL_B, 8'h00);
    rd(IDX_FLAGS, 8'h00);
    // Capture from capture-pin edges, rising then falling, counter clocked by count-pin edges
    wr(IDX_CNT_H, 8'h00);
    wr(IDX_CNT_L, 8'h00);
    global_irq_enable <= 1'b0;
    wr(IDX_CTL_B, {2'h1, 3'h0, CS_EXT_RISE});
    pins.count_pulses(5);
    pins.set_cap(1'b1);
    repeat (6) @(posedge pclk);
    check(capture_irq, 1'b0);
    rd(IDX_ICR_L, 8'h05);
    rd(IDX_ICR_H, 8'h00);
    rd(IDX_FLAGS, 8'h20);
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge pclk);
    check(capture_irq, 1'b1);
    capture_irq_ack <= 1'b1;
    @(posedge pclk);
    capture_irq_ack <= 1'b0;
    rd(IDX_FLAGS, 8'h00);
    wr(IDX_CTL_B, {5'h0, CS_EXT_FALL});
    pins.count_pulses(3);
    pins.set_cap(1'b0);
    repeat (6) @(posedge pclk);
    rd(IDX_ICR_L, 8'h08);
    wr(IDX_FLAGS, 8'h20);
    rd(IDX_FLAGS, 8'h00);
    // Capture pin ignored while capture value is the top
    wr(IDX_ICR_H, 8'h01);
    wr(IDX_ICR_L, 8'h00);
    wr(IDX_CTL_B, 8'h58);
    pins.set_cap(1'b1);
    repeat (6) @(posedge pclk);
    rd(IDX_ICR_L, 8'h00);
    rd(IDX_ICR_H, 8'h01);
    rd(IDX_FLAGS, 8'h00);
    // Comparator as capture source; switching away from a high pin
    // gives only a falling edge, ignored on rising select
    wr(IDX_CTL_B, 8'h40);
    wr(IDX_CAP_SRC, 8'h01);
    pins.set_cmp(1'b1);
    repeat (6) @(posedge pclk);
    rd(IDX_ICR_L, 8'h08);
    rd(IDX_FLAGS, 8'h20);
    give_verdict();
  end
endmodule : stc_timer_ctl_tb
